// ==== verilog/ats_gate_defs.svh ====
// constants for the isolated device translation gate
`ifndef ATS_GATE_DEFS_SVH
`define ATS_GATE_DEFS_SVH

`define ADDR_W 32
`define DATA_W 32
`define PAGE_W 20
`define PAGE_OFS_W 12
`define CFG_ADDR_W 12
`define CACHE_ENTRIES 4
`define CACHE_IDX_W 2
`define OUTSTANDING_W 8

// translation-service extended capability in config space
`define CFG_ATS_HDR_OFS 12'h100
`define CFG_ATS_CAPCTL_OFS 12'h104
`define ATS_CAP_ID 16'h000f
`define ATS_CAP_VER 4'h1
`define ATS_NEXT_PTR 12'h000
// capability register fields
`define ATS_CAP_INVQ_DEPTH 5'h00
`define ATS_CAP_PAGE_ALIGNED 1'b1
// control register fields, in the upper half of the dword
`define ATS_CTL_EN_BIT 31
`define ATS_CTL_STU_LSB 16
`define ATS_CTL_STU_W 5
`define ATS_CTL_EN_RST 1'b0
`define ATS_CTL_STU_RST 5'h00

`endif

// ==== verilog/ats_gate_pkg.sv ====
// types shared by the translation gate and its cache
`default_nettype none
`include "ats_gate_defs.svh"
package ats_gate_pkg;

	typedef enum logic [1:0]
	{
		FAB_MEM_RD = 2'b00,
		FAB_MEM_WR = 2'b01,
		FAB_TRANS_REQ = 2'b10
	} fab_kind_type;

	typedef struct packed
	{
		logic bypass;
		logic write;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
	} core_req_type;

	typedef struct packed
	{
		logic ok;
		logic [`DATA_W-1:0] rdata;
	} core_rsp_type;

	typedef struct packed
	{
		fab_kind_type kind;
		logic translated;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
	} fab_req_type;

	typedef struct packed
	{
		logic ok;
		logic [`PAGE_W-1:0] hpa_page;
	} tcpl_type;

	typedef struct packed
	{
		logic ok;
		logic [`DATA_W-1:0] rdata;
	} rcpl_type;

	typedef struct packed
	{
		logic all;
		logic [`PAGE_W-1:0] page;
	} inv_type;

	typedef struct packed
	{
		logic write;
		logic [`CFG_ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
	} cfg_req_type;

endpackage
`default_nettype wire

// ==== verilog/device_translation_cache.sv ====
// fully associative page translation cache, private to the gate
`timescale 1ns/1ps
`default_nettype none
`include "ats_gate_defs.svh"
module device_translation_cache
	import ats_gate_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [`PAGE_W-1:0] lookup_page_in,
	output logic hit_out,
	output logic [`PAGE_W-1:0] hpa_page_out,
	input wire logic fill_in,
	input wire logic [`PAGE_W-1:0] fill_page_in,
	input wire logic [`PAGE_W-1:0] fill_hpa_in,
	input wire logic inv_in,
	input wire inv_type inv_cmd_in
);

	function automatic logic page_match(input logic v,
		input logic [`PAGE_W-1:0] a, input logic [`PAGE_W-1:0] b);
		page_match = v && (a == b);
	endfunction

	logic [`CACHE_ENTRIES-1:0] valid_q;
	logic [`CACHE_ENTRIES-1:0] valid_d;
	logic [`PAGE_W-1:0] tag_q [`CACHE_ENTRIES];
	logic [`PAGE_W-1:0] tag_d [`CACHE_ENTRIES];
	logic [`PAGE_W-1:0] hpa_q [`CACHE_ENTRIES];
	logic [`PAGE_W-1:0] hpa_d [`CACHE_ENTRIES];
	logic [`CACHE_IDX_W-1:0] victim_q;
	logic [`CACHE_IDX_W-1:0] victim_d;

	always_comb
	begin
		hit_out = 1'b0;
		hpa_page_out = '0;
		for (int i = 0; i < `CACHE_ENTRIES; i++)
		begin
			if (page_match(valid_q[i], tag_q[i], lookup_page_in))
			begin
				hit_out = 1'b1;
				hpa_page_out = hpa_q[i];
			end
		end
	end

	always_comb
	begin
		valid_d = valid_q;
		victim_d = victim_q;
		for (int i = 0; i < `CACHE_ENTRIES; i++)
		begin
			tag_d[i] = tag_q[i];
			hpa_d[i] = hpa_q[i];
			if (inv_in && (inv_cmd_in.all
				|| page_match(valid_q[i], tag_q[i], inv_cmd_in.page)))
			begin
				valid_d[i] = 1'b0;
			end
		end
		// round-robin victim; good enough for a few entries
		if (fill_in)
		begin
			valid_d[victim_q] = 1'b1;
			tag_d[victim_q] = fill_page_in;
			hpa_d[victim_q] = fill_hpa_in;
			victim_d = victim_q + 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			valid_q <= '0;
			victim_q <= '0;
			for (int i = 0; i < `CACHE_ENTRIES; i++)
			begin
				tag_q[i] <= '0;
				hpa_q[i] <= '0;
			end
		end
		else
		begin
			valid_q <= valid_d;
			victim_q <= victim_d;
			for (int i = 0; i < `CACHE_ENTRIES; i++)
			begin
				tag_q[i] <= tag_d[i];
				hpa_q[i] <= hpa_d[i];
			end
		end
	end

endmodule
`default_nettype wire

// ==== verilog/isolated_device_translation_gate.sv ====
// isolation partition between the device core and the root complex link
`timescale 1ns/1ps
`default_nettype none
`include "ats_gate_defs.svh"
// Function
// - Translated host addresses never reach any core-facing output.
// - All root-complex link ports belong to this partition only.
// - Core only submits requests; the partition alone drives the fabric.
// - Holds the translation cache; follows request, completion, invalidation flow.
// - Implements translation capability header, capability and control registers.
// - Bypass-marked core requests go out untranslated without cache lookup.
// - Core has no read or write path into translation or data cache.
// - Any translated-address-tagged data cache lives inside this partition.
// - Invalidate completion waits until stale fabric writes reach global observation.
// - Remap indication is registered but unused; bypass, disabled and failed-translation requests go out untranslated.
module isolated_device_translation_gate
	import ats_gate_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic core_req_valid_in,
	input wire core_req_type core_req_in,
	output logic core_req_ready_out,
	output logic core_done_out,
	output core_rsp_type core_rsp_out,
	output logic fab_req_valid_out,
	output fab_req_type fab_req_out,
	input wire logic fab_req_ready_in,
	input wire logic fab_tcpl_valid_in,
	input wire tcpl_type fab_tcpl_in,
	input wire logic fab_rcpl_valid_in,
	input wire rcpl_type fab_rcpl_in,
	input wire logic fab_go_in,
	input wire logic fab_inv_valid_in,
	input wire inv_type fab_inv_in,
	output logic fab_inv_done_out,
	input wire logic remap_enabled_in,
	input wire logic cfg_valid_in,
	input wire cfg_req_type cfg_req_in,
	output logic cfg_rvalid_out,
	output logic [`DATA_W-1:0] cfg_rdata_out
);

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_LOOKUP = 3'b001,
		ST_SEND = 3'b010,
		ST_TWAIT = 3'b011,
		ST_RWAIT = 3'b100
	} gate_state_type;

	////////////////////////////////////////////////////////////////////////
	gate_state_type state_q, state_d;
	core_req_type req_q, req_d;
	logic ready_q, ready_d;
	logic done_q, done_d;
	core_rsp_type rsp_q, rsp_d;
	logic fvalid_q, fvalid_d;
	fab_req_type freq_q, freq_d;
	logic [`OUTSTANDING_W-1:0] outst_q, outst_d;
	logic inv_pend_q, inv_pend_d;
	inv_type inv_q, inv_d;
	logic inv_done_q, inv_done_d;
	logic remap_q;
	logic cache_hit;
	logic [`PAGE_W-1:0] cache_hpa;
	logic cache_fill;
	logic cache_inv;
	logic inv_clear;
	logic fab_fire;
	logic ats_en_q, ats_en_d;
	logic [`ATS_CTL_STU_W-1:0] stu_q, stu_d;
	logic cfg_rvalid_q, cfg_rvalid_d;
	logic [`DATA_W-1:0] cfg_rdata_q, cfg_rdata_d;

	// no data cache; nothing tagged outside
	// cache ports reach only this module's logic
	device_translation_cache cache_u (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.lookup_page_in(req_q.addr[`ADDR_W-1:`PAGE_OFS_W]),
		.hit_out(cache_hit),
		.hpa_page_out(cache_hpa),
		.fill_in(cache_fill),
		.fill_page_in(req_q.addr[`ADDR_W-1:`PAGE_OFS_W]),
		.fill_hpa_in(fab_tcpl_in.hpa_page),
		.inv_in(cache_inv),
		.inv_cmd_in(inv_q)
	);

	assign fab_fire = fvalid_q && fab_req_ready_in;

	////////////////////////////////////////////////////////////////////////
	// request sequencing
	always_comb
	begin
		state_d = state_q;
		req_d = req_q;
		done_d = 1'b0;
		rsp_d = rsp_q;
		fvalid_d = fvalid_q;
		freq_d = freq_q;
		cache_fill = 1'b0;
		cache_inv = 1'b0;
		inv_clear = 1'b0;
		inv_done_d = 1'b0;
		// count posted writes until observed globally
		outst_d = outst_q
			+ (`OUTSTANDING_W)'(fab_fire && freq_q.kind == FAB_MEM_WR)
			- (`OUTSTANDING_W)'(fab_go_in);
		unique case (state_q)
			ST_IDLE:
			begin
				// core only submits; fabric driven from here
				if (core_req_valid_in && ready_q)
				begin
					req_d = core_req_in;
					state_d = ST_LOOKUP;
				end
				else if (inv_pend_q && outst_q == '0)
				begin
					cache_inv = 1'b1;
					inv_clear = 1'b1;
					inv_done_d = 1'b1;
				end
			end
			ST_LOOKUP:
			begin
				freq_d.kind = req_q.write ? FAB_MEM_WR : FAB_MEM_RD;
				freq_d.wdata = req_q.wdata;
				freq_d.addr = req_q.addr;
				freq_d.translated = 1'b0;
				fvalid_d = 1'b1;
				state_d = ST_SEND;
				if (req_q.bypass || !ats_en_q)
				begin
					freq_d.translated = 1'b0;
				end
				// hit carries the host physical address
				else if (cache_hit)
				begin
					freq_d.translated = 1'b1;
					freq_d.addr = {cache_hpa,
						req_q.addr[`PAGE_OFS_W-1:0]};
				end
				else
				begin
					freq_d.kind = FAB_TRANS_REQ;
					freq_d.addr = {req_q.addr[`ADDR_W-1:`PAGE_OFS_W],
						`PAGE_OFS_W'(0)};
				end
			end
			ST_SEND:
			begin
				if (fab_fire)
				begin
					fvalid_d = 1'b0;
					unique case (freq_q.kind)
						FAB_TRANS_REQ:
						begin
							state_d = ST_TWAIT;
						end
						FAB_MEM_RD:
						begin
							state_d = ST_RWAIT;
						end
						default:
						begin
							// posted write ends for the core here
							done_d = 1'b1;
							rsp_d.ok = 1'b1;
							rsp_d.rdata = '0;
							state_d = ST_IDLE;
						end
					endcase
				end
			end
			ST_TWAIT:
			begin
				if (fab_tcpl_valid_in)
				begin
					freq_d.kind = req_q.write ? FAB_MEM_WR : FAB_MEM_RD;
					fvalid_d = 1'b1;
					state_d = ST_SEND;
					// fill on success, else fall back untranslated
					if (fab_tcpl_in.ok && ats_en_q)
					begin
						cache_fill = 1'b1;
						freq_d.translated = 1'b1;
						freq_d.addr = {fab_tcpl_in.hpa_page,
							req_q.addr[`PAGE_OFS_W-1:0]};
					end
					else
					begin
						freq_d.translated = 1'b0;
						freq_d.addr = req_q.addr;
					end
				end
			end
			ST_RWAIT:
			begin
				if (fab_rcpl_valid_in)
				begin
					// only data returns, never an address
					done_d = 1'b1;
					rsp_d.ok = fab_rcpl_in.ok;
					rsp_d.rdata = fab_rcpl_in.rdata;
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
		// a new invalidation in the clearing cycle is kept
		inv_pend_d = (inv_pend_q && !inv_clear) || fab_inv_valid_in;
		inv_d = inv_q;
		if (fab_inv_valid_in)
		begin
			inv_d = fab_inv_in;
			inv_d.all = fab_inv_in.all || (inv_pend_q && !inv_clear);
		end
		// hold the core off while an invalidation waits
		ready_d = (state_d == ST_IDLE) && !inv_pend_d;
	end

	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_q <= ST_IDLE;
			req_q <= '0;
			ready_q <= 1'b0;
			done_q <= 1'b0;
			rsp_q <= '0;
			fvalid_q <= 1'b0;
			freq_q <= '0;
			outst_q <= '0;
			inv_pend_q <= 1'b0;
			inv_q <= '0;
			inv_done_q <= 1'b0;
			remap_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			req_q <= req_d;
			ready_q <= ready_d;
			done_q <= done_d;
			rsp_q <= rsp_d;
			fvalid_q <= fvalid_d;
			freq_q <= freq_d;
			outst_q <= outst_d;
			inv_pend_q <= inv_pend_d;
			inv_q <= inv_d;
			inv_done_q <= inv_done_d;
			// remap indication from the root complex
			remap_q <= remap_enabled_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// translation capability configuration space
	always_comb
	begin
		ats_en_d = ats_en_q;
		stu_d = stu_q;
		cfg_rvalid_d = cfg_valid_in && !cfg_req_in.write;
		cfg_rdata_d = '0;
		if (cfg_valid_in && cfg_req_in.write
			&& cfg_req_in.addr == `CFG_ATS_CAPCTL_OFS)
		begin
			ats_en_d = cfg_req_in.wdata[`ATS_CTL_EN_BIT];
			stu_d = cfg_req_in.wdata[`ATS_CTL_STU_LSB +: `ATS_CTL_STU_W];
		end
		if (cfg_valid_in && !cfg_req_in.write)
		begin
			if (cfg_req_in.addr == `CFG_ATS_HDR_OFS)
			begin
				cfg_rdata_d = {`ATS_NEXT_PTR, `ATS_CAP_VER, `ATS_CAP_ID};
			end
			else if (cfg_req_in.addr == `CFG_ATS_CAPCTL_OFS)
			begin
				cfg_rdata_d[`ATS_CTL_EN_BIT] = ats_en_q;
				cfg_rdata_d[`ATS_CTL_STU_LSB +: `ATS_CTL_STU_W] = stu_q;
				cfg_rdata_d[5] = `ATS_CAP_PAGE_ALIGNED;
				cfg_rdata_d[4:0] = `ATS_CAP_INVQ_DEPTH;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ats_en_q <= `ATS_CTL_EN_RST;
			stu_q <= `ATS_CTL_STU_RST;
			cfg_rvalid_q <= 1'b0;
			cfg_rdata_q <= '0;
		end
		else
		begin
			ats_en_q <= ats_en_d;
			stu_q <= stu_d;
			cfg_rvalid_q <= cfg_rvalid_d;
			cfg_rdata_q <= cfg_rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link outputs come only from partition flops
	assign core_req_ready_out = ready_q;
	assign core_done_out = done_q;
	assign core_rsp_out = rsp_q;
	assign fab_req_valid_out = fvalid_q;
	assign fab_req_out = freq_q;
	assign fab_inv_done_out = inv_done_q;
	assign cfg_rvalid_out = cfg_rvalid_q;
	assign cfg_rdata_out = cfg_rdata_q;

endmodule
`default_nettype wire

// ==== testbench/gate_checker_assertions.sv ====
// port-level assertions for the translation gate
`timescale 1ns/1ps
`default_nettype none
`include "ats_gate_defs.svh"
module gate_checker
	import ats_gate_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic core_req_valid_in,
	input wire core_req_type core_req_in,
	input wire logic core_req_ready_out,
	input wire logic fab_req_valid_out,
	input wire fab_req_type fab_req_out,
	input wire logic fab_req_ready_in,
	input wire logic fab_go_in,
	input wire logic fab_inv_valid_in,
	input wire logic fab_inv_done_out,
	input wire logic cfg_valid_in,
	input wire cfg_req_type cfg_req_in,
	input wire logic cfg_rvalid_out,
	input wire logic [`DATA_W-1:0] cfg_rdata_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	logic en_q;
	logic [7:0] wr_q;
	wire take = core_req_valid_in && core_req_ready_out;
	wire wr_go = fab_req_valid_out && fab_req_ready_in
		&& fab_req_out.kind == FAB_MEM_WR;
	wire ctl_wr = cfg_valid_in && cfg_req_in.addr == `CFG_ATS_CAPCTL_OFS;
	////////////////////////////////////////////////////////////////////////
	// writes still short of global observation
	always_ff @(posedge mclk_in or negedge resetn_in)
		if (!resetn_in)
		begin
			en_q <= 1'b0;
			wr_q <= 8'h00;
		end
		else
		begin
			wr_q <= wr_q + 8'(wr_go) - 8'(fab_go_in);
			if (ctl_wr && cfg_req_in.write)
				en_q <= cfg_req_in.wdata[`ATS_CTL_EN_BIT];
		end
	property p_hold;
		fab_req_valid_out && !fab_req_ready_in |=>
			fab_req_valid_out && $stable(fab_req_out);
	endproperty
	a_hold: assert property(p_hold) else $error("fabric req dropped");
	property p_bypass;
		take && core_req_in.bypass |-> ##2 fab_req_valid_out
			&& !fab_req_out.translated
			&& fab_req_out.addr == $past(core_req_in.addr, 2);
	endproperty
	a_bypass: assert property(p_bypass) else $error("bypass bad");
	property p_off;
		fab_req_valid_out && !en_q |-> !fab_req_out.translated
			&& fab_req_out.kind != FAB_TRANS_REQ;
	endproperty
	a_off: assert property(p_off) else $error("translated while off");
	property p_drain;
		fab_inv_done_out |-> wr_q == 8'h00;
	endproperty
	a_drain: assert property(p_drain) else $error("inv done early");
	property p_inv;
		fab_inv_valid_in && core_req_ready_out && !core_req_valid_in
			&& wr_q == 8'h00 |-> ##2 fab_inv_done_out;
	endproperty
	a_inv: assert property(p_inv) else $error("inv done late");
	property p_take;
		take |=> !core_req_ready_out;
	endproperty
	a_take: assert property(p_take) else $error("ready after take");
	property p_hdr;
		cfg_valid_in && !cfg_req_in.write
			&& cfg_req_in.addr == `CFG_ATS_HDR_OFS |=> cfg_rvalid_out
			&& cfg_rdata_out == {`ATS_NEXT_PTR, `ATS_CAP_VER, `ATS_CAP_ID};
	endproperty
	a_hdr: assert property(p_hdr) else $error("header bad");
	property p_ctl;
		ctl_wr && !cfg_req_in.write |=> cfg_rvalid_out
			&& cfg_rdata_out[31] == $past(en_q) && cfg_rdata_out[5:0] == 6'h20;
	endproperty
	a_ctl: assert property(p_ctl) else $error("control read bad");
	c_bypass: cover property(take && core_req_in.bypass);
	c_miss: cover property(fab_req_valid_out
		&& fab_req_out.kind == FAB_TRANS_REQ);
	c_inv: cover property(fab_inv_done_out);
endmodule
bind isolated_device_translation_gate gate_checker chk (.*);
`default_nettype wire

// ==== testbench/fabric_model.sv ====
// root complex side: translation, memory and observation
`timescale 1ns/1ps
`default_nettype none
module fabric_model
	import ats_gate_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic stall_in,
	input wire logic fail_in,
	input wire logic req_valid_in,
	input wire fab_req_type req_in,
	output logic ready_out,
	output logic tcpl_valid_out,
	output tcpl_type tcpl_out,
	output logic rcpl_valid_out,
	output rcpl_type rcpl_out,
	output logic go_out,
	output logic remap_out
);
	logic [3:0] go_q;
	logic [1:0] wait_q;
	logic busy_q;
	fab_req_type last_q;
	wire take = req_valid_in && ready_out;
	assign ready_out = !stall_in;
	assign go_out = go_q[3];
	assign remap_out = 1'b1;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in or negedge resetn_in)
		if (!resetn_in)
		begin
			go_q <= '0;
			busy_q <= 1'b0;
			wait_q <= '0;
			tcpl_valid_out <= 1'b0;
			rcpl_valid_out <= 1'b0;
			tcpl_out <= '0;
			rcpl_out <= '0;
		end
		else
		begin
			tcpl_valid_out <= 1'b0;
			rcpl_valid_out <= 1'b0;
			// released lines flip so stale data never matches
			tcpl_out <= ~tcpl_out;
			rcpl_out <= ~rcpl_out;
			go_q <= {go_q[2:0], take && req_in.kind == FAB_MEM_WR};
			wait_q <= busy_q ? wait_q + 2'd1 : 2'd0;
			if (take && req_in.kind != FAB_MEM_WR)
			begin
				busy_q <= 1'b1;
				last_q <= req_in;
			end
			else if (busy_q && wait_q == 2'd2)
			begin
				busy_q <= 1'b0;
				tcpl_valid_out <= last_q.kind == FAB_TRANS_REQ;
				rcpl_valid_out <= last_q.kind != FAB_TRANS_REQ;
				tcpl_out <= '{!fail_in, last_q.addr[31:12] ^ 20'h5a5a5};
				rcpl_out <= '{1'b1, last_q.addr ^ 32'h3c3c0f0f};
			end
		end
endmodule
`default_nettype wire

// ==== testbench/isolated_device_translation_gate_tb.sv ====
// self-checking bench for the translation gate
`timescale 1ns/1ps
`default_nettype none
`include "ats_gate_defs.svh"
module isolated_device_translation_gate_tb
	import ats_gate_pkg::*;
;
	logic mclk_in = 0;
	logic resetn_in = 0;
	logic core_req_valid_in = 0;
	core_req_type core_req_in = '0;
	logic core_req_ready_out, core_done_out, fab_req_valid_out;
	core_rsp_type core_rsp_out;
	fab_req_type fab_req_out;
	logic fab_req_ready_in, fab_tcpl_valid_in, fab_rcpl_valid_in, fab_go_in;
	tcpl_type fab_tcpl_in;
	rcpl_type fab_rcpl_in;
	logic fab_inv_valid_in = 0;
	inv_type fab_inv_in = '0;
	logic fab_inv_done_out, remap_enabled_in, cfg_rvalid_out;
	logic cfg_valid_in = 0;
	cfg_req_type cfg_req_in = '0;
	logic [31:0] cfg_rdata_out;
	logic stall = 0;
	logic fail = 0;
	logic en = 0;
	logic [32:0] e;
	logic [32:0] rq[$];
	logic [31:0] gq[$];
	int seed = 32'hdec22e05;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	int inv_sent = 0;
	int inv_seen = 0;
	always #25 mclk_in = ~mclk_in;
	isolated_device_translation_gate uut (.*);
	fabric_model far (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.stall_in(stall), .fail_in(fail), .req_valid_in(fab_req_valid_out),
		.req_in(fab_req_out), .ready_out(fab_req_ready_in),
		.tcpl_valid_out(fab_tcpl_valid_in), .tcpl_out(fab_tcpl_in),
		.rcpl_valid_out(fab_rcpl_valid_in), .rcpl_out(fab_rcpl_in),
		.go_out(fab_go_in), .remap_out(remap_enabled_in));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", n, x, s);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic op(input logic b, input logic w, input logic [31:0] a);
		@(negedge mclk_in);
		core_req_valid_in = 1;
		core_req_in = '{b, w, a, $random(seed)};
		rq.push_back({!w, ((b || !en || fail) ? a
			: {a[31:12] ^ 20'h5a5a5, a[11:0]}) ^ 32'h3c3c0f0f});
		@(posedge mclk_in);
		while (!core_req_ready_out)
			@(posedge mclk_in);
		@(negedge mclk_in);
		core_req_valid_in = 0;
		core_req_in = ~core_req_in;
		while (core_done_out !== 1'b1)
			@(negedge mclk_in);
	endtask
	// a read passes its expected data in d
	task automatic cfg(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(negedge mclk_in);
		cfg_valid_in = 1;
		cfg_req_in = '{w, a, d};
		if (!w)
			gq.push_back(d);
		@(negedge mclk_in);
		cfg_valid_in = 0;
	endtask
	task automatic inv(input logic all, input logic [19:0] p);
		@(negedge mclk_in);
		fab_inv_valid_in = 1;
		fab_inv_in = '{all, p};
		inv_sent++;
		@(negedge mclk_in);
		fab_inv_valid_in = 0;
		// long enough for a stalled write to drain first
		repeat (24) @(negedge mclk_in);
	endtask
	always @(negedge mclk_in)
		stall = 1'($random(seed));
	always @(negedge mclk_in)
	begin
		if (core_done_out === 1'b1)
		begin
			e = rq.pop_front();
			check("ok", 32'(core_rsp_out.ok), 1);
			if (e[32])
				check("rdata", core_rsp_out.rdata, e[31:0]);
		end
		if (cfg_rvalid_out === 1'b1)
			check("cfg", cfg_rdata_out, gq.pop_front());
		if (fab_inv_done_out === 1'b1)
			inv_seen++;
	end
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc > 6000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	initial
	begin
		repeat (6) @(posedge mclk_in);
		@(negedge mclk_in);
		resetn_in = 1;
		repeat (2) @(negedge mclk_in);
		cfg(0, `CFG_ATS_HDR_OFS, {`ATS_NEXT_PTR, `ATS_CAP_VER, `ATS_CAP_ID});
		cfg(0, `CFG_ATS_CAPCTL_OFS, 32'h0000_0020);
		cfg(0, 12'h200, 32'h0);
		op(0, 0, 32'h0001_2345);
		cfg(1, `CFG_ATS_CAPCTL_OFS, 32'h8003_0000);
		en = 1;
		cfg(0, `CFG_ATS_CAPCTL_OFS, 32'h8003_0020);
		for (int i = 0; i < 40; i++)
			op(1'($random(seed)), 1'($random(seed)),
				32'($random(seed)) & 32'h0000_7ffc);
		// invalidate while a write is in flight
		fork
			op(0, 1, 32'h0000_3010);
			inv(1, 20'h0);
		join
		inv(0, 20'h3);
		op(0, 0, 32'h0000_3018);
		fail = 1;
		inv(1, 20'h0);
		op(0, 0, 32'h0000_1040);
		fail = 0;
		cfg(1, `CFG_ATS_CAPCTL_OFS, 32'h0);
		en = 0;
		inv(1, 20'h0);
		op(0, 0, 32'h0000_2080);
		cfg(0, `CFG_ATS_CAPCTL_OFS, 32'h0000_0020);
		repeat (10) @(negedge mclk_in);
		check("inv", inv_seen, inv_sent);
		end_sim();
	end
endmodule
`default_nettype wire
